/* File: verilog/vic_regs.svh */
// register offsets, field positions, reset values and vector constants of the interrupt controller
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH
// ==========================================================
// register byte offsets
`define OFF_CTRL_ONE 12'h000
`define OFF_CTRL_TWO 12'h004
`define OFF_FLAG_BASE 12'h008
`define OFF_ENA_BASE 12'h01c
`define OFF_PRIO_BASE 12'h030
`define OFF_PEND 12'h078
`define OFF_CSW 12'h07c
`define OFF_CCW 12'h080
`define OFF_EVT_STS 12'h084
`define OFF_EVT_CLR 12'h088
`define OFF_EVT_ENA 12'h08c
`define NUM_FLAG_REGS 5
`define NUM_PRIO_REGS 18
// ==========================================================
// field positions
`define NEST_DIS_BIT 15
`define ALT_SEL_BIT 15
`define TRAP_LSB 1
`define DIV0_BIT 6
`define IPL_LSB 5
`define TOP_BIT 3
`define PEND_LVL_LSB 8
// ==========================================================
// reset values and vector constants
`define CTRL_RST 16'h0000
`define IPL_RST 3'h0
`define VT_PRI_BASE 24'h000004
`define VT_ALT_BASE 24'h000104
`define USER_VEC_FIRST 7'h08
`define TRAP_LVL_TOP 4'hf
`endif

/* File: verilog/vic_pkg.sv */
// types shared by the interrupt controller files
package vic_pkg;
  typedef logic [2:0] prio_t;
  typedef logic [3:0] level_t;
  typedef logic [6:0] vec_t;
  // register decode result
  typedef enum logic [3:0] {
    RK_NONE, RK_CTRL1, RK_CTRL2, RK_FLAG, RK_ENA, RK_PRIO,
    RK_PEND, RK_CSW, RK_CCW, RK_ESTS, RK_ECLR, RK_EENA
  } reg_kind_t;
endpackage : vic_pkg

/* File: verilog/vic_select.sv */
// priority selection over user interrupt sources
`timescale 1ns/1ps
module vic_select
  import vic_pkg::*;
#(
  parameter int N = 72
) (
  // requests
  input wire logic [N-1:0] req,
  input wire logic [3*N-1:0] prio,
  // current cpu level
  input wire logic [2:0] floor,
  input wire logic blocked,
  // winner
  output logic found,
  output logic [6:0] idx,
  output prio_t lvl
);
  // strict greater keeps the lower request number on a tie
  always_comb begin
    found = 1'b0;
    idx = 7'h00;
    lvl = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && !blocked && prio[3*i +: 3] > floor && prio[3*i +: 3] > lvl) begin
        found = 1'b1;
        idx = 7'(i);
        lvl = prio[3*i +: 3];
      end
    end
  end
endmodule : vic_select

/* File: verilog/vic_top.sv */
// vectored interrupt and trap controller with apb register access
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "vic_regs.svh"
module vic_top
  import vic_pkg::*;
#(
  parameter int NSRC = 72
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests and external pins
  input wire logic [NSRC-1:0] src_evt,
  input wire logic [4:0] ext_pin,
  // trap events: osc, addr, stack, math, dma; divide by zero
  input wire logic [4:0] trap_evt,
  input wire logic div0_evt,
  // processor core
  input wire logic cpu_ack,
  input wire logic trap_done,
  output logic cpu_req,
  output logic [6:0] cpu_pending_vector_number,
  output logic [23:0] cpu_vec_addr,
  output logic [3:0] cpu_level,
  output logic irq
);
  // ==========================================================
  // state
  logic [15:0] ctrl1_q;
  logic [15:0] ctrl2_q;
  logic [79:0] flags_q;
  logic [79:0] ena_q;
  logic [15:0] prio_q [`NUM_PRIO_REGS];
  logic [2:0] ipl_q;
  logic top_q;
  logic [4:0] pin_q;
  vec_t rep_vec_q;
  level_t rep_lvl_q;
  logic [1:0] evt_sts_q;
  logic [1:0] evt_ena_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic err_q;
  logic req_q;
  vec_t vnum_q;
  logic [23:0] vaddr_q;
  level_t lvl_q;
  logic irq_q;

  // ==========================================================
  // apb decode
  reg_kind_t kind;
  logic [4:0] widx;
  logic wr_en;
  logic setup;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && ready_q && pwrite;

  // address ranges are checked in order; an unmapped address answers with an error
  always_comb begin
    kind = RK_NONE;
    widx = 5'h00;
    if (paddr[1:0] != 2'b00) begin
      kind = RK_NONE;
    end else if (paddr == `OFF_CTRL_ONE) begin
      kind = RK_CTRL1;
    end else if (paddr == `OFF_CTRL_TWO) begin
      kind = RK_CTRL2;
    end else if (paddr >= `OFF_FLAG_BASE && paddr < `OFF_ENA_BASE) begin
      kind = RK_FLAG;
      widx = 5'((paddr - `OFF_FLAG_BASE) >> 2);
    end else if (paddr >= `OFF_ENA_BASE && paddr < `OFF_PRIO_BASE) begin
      kind = RK_ENA;
      widx = 5'((paddr - `OFF_ENA_BASE) >> 2);
    end else if (paddr >= `OFF_PRIO_BASE && paddr < `OFF_PEND) begin
      kind = RK_PRIO;
      widx = 5'((paddr - `OFF_PRIO_BASE) >> 2);
    end else if (paddr == `OFF_PEND) begin
      kind = RK_PEND;
    end else if (paddr == `OFF_CSW) begin
      kind = RK_CSW;
    end else if (paddr == `OFF_CCW) begin
      kind = RK_CCW;
    end else if (paddr == `OFF_EVT_STS) begin
      kind = RK_ESTS;
    end else if (paddr == `OFF_EVT_CLR) begin
      kind = RK_ECLR;
    end else if (paddr == `OFF_EVT_ENA) begin
      kind = RK_EENA;
    end
  end

  // ==========================================================
  // external pins: edge detect with per pin polarity
  logic [4:0] pin_edge;
  logic [NSRC-1:0] src_set;
  localparam int EXT_SRC [5] = '{0, 20, 29, 53, 54};
  always_comb begin
    src_set = src_evt;
    for (int p = 0; p < 5; p++) begin
      pin_edge[p] = ctrl2_q[p] ? (pin_q[p] && !ext_pin[p]) : (!pin_q[p] && ext_pin[p]);
      src_set[EXT_SRC[p]] = src_evt[EXT_SRC[p]] | pin_edge[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 5'h00;
    end else begin
      pin_q <= ext_pin;
    end
  end

  // ==========================================================
  // global control: nesting disable, trap status, table select, polarity
  logic [15:0] trap_set;
  assign trap_set = {9'h000, div0_evt, trap_evt[4], trap_evt[3] | div0_evt, trap_evt[2:0], 1'b0};

  // trap status bits are software writable, but a trap in the write cycle still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= `CTRL_RST;
      ctrl2_q <= `CTRL_RST;
    end else begin
      ctrl1_q <= ctrl1_q | trap_set;
      if (wr_en && kind == RK_CTRL1) begin
        ctrl1_q <= (pwdata[15:0] & 16'h807e) | trap_set;
      end
      if (wr_en && kind == RK_CTRL2) begin
        ctrl2_q <= pwdata[15:0] & 16'h801f;
      end
    end
  end

  // ==========================================================
  // request flags and enables, sixteen sources per word
  logic [79:0] set_wide;
  assign set_wide = 80'(src_set);

  // set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 80'h0;
    end else begin
      flags_q <= flags_q | set_wide;
      if (wr_en && kind == RK_FLAG) begin
        flags_q[widx*16 +: 16] <= pwdata[15:0] | set_wide[widx*16 +: 16];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_q <= 80'h0;
    end else if (wr_en && kind == RK_ENA) begin
      ena_q[widx*16 +: 16] <= pwdata[15:0];
    end
  end

  // four sources per priority word, three bits in each nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < `NUM_PRIO_REGS; k++) begin
        prio_q[k] <= `CTRL_RST;
      end
    end else if (wr_en && kind == RK_PRIO) begin
      prio_q[widx] <= pwdata[15:0] & 16'h7777;
    end
  end

  // ==========================================================
  // selection of the pending request
  logic [3*NSRC-1:0] prio_flat;
  logic [NSRC-1:0] user_req;
  logic user_found;
  logic [6:0] user_idx;
  prio_t user_lvl;
  level_t full_lvl;
  assign full_lvl = {top_q, ipl_q};
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      prio_flat[3*i +: 3] = prio_q[i/4][4*(i%4) +: 3];
      user_req[i] = flags_q[i] && ena_q[i];
    end
  end

  // ipl of 7 leaves no level above it, so user requests are off
  vic_select #(
    .N(NSRC)
  ) u_select (
    .req(user_req),
    .prio(prio_flat),
    .floor(ipl_q),
    .blocked(top_q),
    .found(user_found),
    .idx(user_idx),
    .lvl(user_lvl)
  );

  // traps: lowest vector first, fixed levels above every user level
  logic trap_found;
  vec_t trap_vec;
  level_t trap_lvl;
  always_comb begin
    trap_found = 1'b0;
    trap_vec = 7'h00;
    trap_lvl = 4'h0;
    for (int v = 5; v >= 1; v--) begin
      if (ctrl1_q[v] && (`TRAP_LVL_TOP - 4'(v)) > full_lvl) begin
        trap_found = 1'b1;
        trap_vec = 7'(v);
        trap_lvl = `TRAP_LVL_TOP - 4'(v);
      end
    end
  end

  vec_t pend_vec;
  level_t pend_lvl;
  logic pend_found;
  assign pend_found = trap_found || user_found;
  assign pend_vec = trap_found ? trap_vec : 7'(user_idx + `USER_VEC_FIRST);
  assign pend_lvl = trap_found ? trap_lvl : {1'b0, user_lvl};

  // report holds the last winner while nothing is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_vec_q <= 7'h00;
      rep_lvl_q <= 4'h0;
    end else if (pend_found) begin
      rep_vec_q <= pend_vec;
      rep_lvl_q <= pend_lvl;
    end
  end

  // ==========================================================
  // cpu level: software writes ipl unless nesting is disabled or an ack is taken in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipl_q <= `IPL_RST;
      top_q <= 1'b0;
    end else begin
      if (cpu_ack && req_q) begin
        ipl_q <= ctrl1_q[`NEST_DIS_BIT] ? 3'h7 : lvl_q[2:0];
        top_q <= lvl_q[3];
      end else begin
        if (wr_en && kind == RK_CSW && !ctrl1_q[`NEST_DIS_BIT]) begin
          ipl_q <= pwdata[`IPL_LSB +: 3];
        end
        if (trap_done) begin
          top_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // request towards the core, vector fetch address from the chosen table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      vnum_q <= 7'h00;
      vaddr_q <= 24'h0;
      lvl_q <= 4'h0;
    end else begin
      req_q <= pend_found && !(cpu_ack && req_q);
      if (pend_found) begin
        vnum_q <= pend_vec;
        lvl_q <= pend_lvl;
        vaddr_q <= (ctrl2_q[`ALT_SEL_BIT] ? `VT_ALT_BASE : `VT_PRI_BASE)
          + {16'h0, pend_vec, 1'b0};
      end
    end
  end

  // ==========================================================
  // event status: bit 0 new request towards core, bit 1 trap flagged
  logic [1:0] evt_set;
  assign evt_set = {|trap_set, pend_found && !req_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sts_q <= 2'h0;
      evt_ena_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      evt_sts_q <= evt_sts_q | evt_set;
      if (wr_en && kind == RK_ECLR) begin
        evt_sts_q <= (evt_sts_q & ~pwdata[1:0]) | evt_set;
      end
      if (wr_en && kind == RK_EENA) begin
        evt_ena_q <= pwdata[1:0];
      end
      irq_q <= |(evt_sts_q & evt_ena_q);
    end
  end

  // ==========================================================
  // read data captured in the setup cycle; one access cycle, no wait states
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    case (kind)
      RK_CTRL1: rmux = {16'h0, ctrl1_q};
      RK_CTRL2: rmux = {16'h0, ctrl2_q};
      RK_FLAG: rmux = {16'h0, flags_q[widx*16 +: 16]};
      RK_ENA: rmux = {16'h0, ena_q[widx*16 +: 16]};
      RK_PRIO: rmux = {16'h0, prio_q[widx]};
      RK_PEND: rmux = {20'h0, rep_lvl_q, 1'b0, rep_vec_q};
      RK_CSW: rmux = {24'h0, ipl_q, 5'h00};
      RK_CCW: rmux = {28'h0, top_q, 3'h0};
      RK_ESTS: rmux = {30'h0, evt_sts_q};
      RK_EENA: rmux = {30'h0, evt_ena_q};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ready_q <= setup;
      err_q <= setup && kind == RK_NONE;
      if (setup) begin
        rdata_q <= rmux;
      end
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign cpu_req = req_q;
  assign cpu_pending_vector_number = vnum_q;
  assign cpu_vec_addr = vaddr_q;
  assign cpu_level = lvl_q;
  assign irq = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_flag_sticky: assert property (src_evt[3] |=> flags_q[3])
    else $error("request flag not set by event");
  chk_enable_gate: assert property (user_found |-> ena_q[user_idx] && flags_q[user_idx])
    else $error("disabled source selected");
  chk_top_blocks: assert property (top_q |-> !user_found)
    else $error("user interrupt while top level bit set");
  chk_level_above: assert property (user_found |-> user_lvl > ipl_q && ipl_q != 3'h7)
    else $error("winner not above cpu level");
  chk_nest_lock: assert property (wr_en && kind == RK_CSW && ctrl1_q[`NEST_DIS_BIT]
    && !(cpu_ack && req_q) |=> ipl_q == $past(ipl_q))
    else $error("cpu level written while nesting disabled");
  chk_table_addr: assert property (pend_found |=> vaddr_q == ($past(ctrl2_q[`ALT_SEL_BIT])
    ? 24'h000104 : 24'h000004) + {16'h0, vnum_q, 1'b0})
    else $error("vector address mismatch");
  chk_report_latch: assert property (user_found && !trap_found
    |=> rep_vec_q == 7'($past(user_idx) + 7'h08))
    else $error("report vector wrong");
  // the acknowledge edge drops the request for one cycle, so it is left out here
  chk_trap_first: assert property (trap_found && !(cpu_ack && req_q)
    |=> req_q && vnum_q < 7'h08)
    else $error("trap not presented first");
  chk_tie_order: assert property (user_found && user_idx > 7'h00 && user_req[0]
    |-> prio_flat[2:0] < user_lvl || prio_flat[2:0] <= ipl_q)
    else $error("tie not resolved to lower number");

  cov_user_taken: cover property (user_found ##1 req_q ##[1:4] cpu_ack);
  cov_trap_taken: cover property (trap_found ##1 req_q && cpu_ack);
  cov_alt_table: cover property (ctrl2_q[`ALT_SEL_BIT] && pend_found);
endmodule : vic_top

/* File: testbench/core_model.sv */
// processor core model that takes presented vectors and records them
`timescale 1ns/1ps
module core_model #(
  parameter int DELAY = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  input wire logic cpu_req,
  input wire logic [6:0] cpu_pending_vector_number,
  input wire logic [23:0] cpu_vec_addr,
  input wire logic [3:0] cpu_level,
  output logic cpu_ack,
  // what was taken
  output logic [6:0] took_vec,
  output logic [23:0] took_addr,
  output logic [3:0] took_lvl,
  output logic [7:0] took_cnt
);
  logic [3:0] wait_q;
  // ==========================================================
  // slow ack: a request must stand DELAY+1 cycles, and acks never come back to back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
      took_cnt <= 8'h00;
      took_vec <= 7'h00;
      took_addr <= 24'h000000;
      took_lvl <= 4'h0;
    end else begin
      cpu_ack <= 1'b0;
      // vector is taken at the edge that samples the ack
      if (cpu_ack && cpu_req) begin
        took_vec <= cpu_pending_vector_number;
        took_addr <= cpu_vec_addr;
        took_lvl <= cpu_level;
        took_cnt <= took_cnt + 8'h01;
      end
      if (cpu_req && !cpu_ack) begin
        if (wait_q == 4'(DELAY)) begin
          cpu_ack <= 1'b1;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule : core_model

/* File: testbench/vectored_interrupt_controller_test.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_regs.svh"
module vectored_interrupt_controller_test;
  import vic_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [71:0] src_evt = 72'h0;
  logic [4:0] ext_pin = 5'h00;
  logic [4:0] trap_evt = 5'h00;
  logic div0_evt = 1'b0;
  logic trap_done = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_ack, cpu_req, irq;
  logic [6:0] cpu_pending_vector_number, took_vec;
  logic [23:0] cpu_vec_addr, took_addr;
  logic [3:0] cpu_level, took_lvl;
  logic [7:0] took_cnt;
  logic [7:0] seen = 8'h00;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  vic_top #(.NSRC(72)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_evt(src_evt),
    .ext_pin(ext_pin), .trap_evt(trap_evt), .div0_evt(div0_evt),
    .cpu_ack(cpu_ack), .trap_done(trap_done), .cpu_req(cpu_req),
    .cpu_pending_vector_number(cpu_pending_vector_number), .cpu_vec_addr(cpu_vec_addr),
    .cpu_level(cpu_level), .irq(irq));
  core_model #(.DELAY(2)) partner (.pclk(pclk), .presetn(presetn),
    .cpu_req(cpu_req), .cpu_pending_vector_number(cpu_pending_vector_number), .cpu_vec_addr(cpu_vec_addr),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .took_vec(took_vec),
    .took_addr(took_addr), .took_lvl(took_lvl), .took_cnt(took_cnt));
  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // pready is sampled at the rising edge that also takes the write and the read data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd
  task automatic fire(input logic [71:0] m);
    @(posedge pclk);
    src_evt <= m;
    @(posedge pclk);
    src_evt <= 72'h0;
  endtask : fire
  // one new vector taken by the core, with its address and level
  task automatic took(input logic [6:0] v, input logic [23:0] a, input logic [3:0] l);
    repeat (60) if (took_cnt == seen) @(posedge pclk);
    @(negedge pclk);
    check(32'(took_cnt - seen), 32'h1);
    seen = took_cnt;
    check({25'h0, took_vec}, {25'h0, v});
    check({8'h0, took_addr}, {8'h0, a});
    check({28'h0, took_lvl}, {28'h0, l});
  endtask : took
  task automatic quiet();
    repeat (12) @(posedge pclk);
    @(negedge pclk);
    check(32'(took_cnt - seen), 32'h0);
    check({31'h0, cpu_req}, 32'h0);
  endtask : quiet
  task automatic tidy();
    wr(`OFF_FLAG_BASE, 32'h0);
    wr(`OFF_CSW, 32'h0);
  endtask : tidy
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(`OFF_CTRL_ONE, 32'h0);
    rd(`OFF_CSW, 32'h0);
    rd(`OFF_PEND, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_user();
    wr(`OFF_PRIO_BASE, 32'h5440);
    wr(`OFF_ENA_BASE, 32'he);
    fire(72'h8);
    took(7'h0b, 24'h00001a, 4'h5);
    rd(`OFF_CSW, 32'ha0);
    rd(`OFF_FLAG_BASE, 32'h8);
    rd(`OFF_PEND, 32'h050b);
    tidy();
    $display("user vector test done");
  endtask : t_user
  task automatic t_tie();
    fire(72'h6);
    took(7'h09, 24'h000016, 4'h4);
    rd(`OFF_FLAG_BASE, 32'h6);
    tidy();
    $display("tie test done");
  endtask : t_tie
  task automatic t_masked();
    wr(`OFF_PRIO_BASE + 12'h004, 32'h7);
    fire(72'h10);
    quiet();
    wr(`OFF_CSW, 32'he0);
    fire(72'h8);
    quiet();
    tidy();
    $display("masking test done");
  endtask : t_masked
  task automatic t_alt();
    wr(`OFF_CTRL_TWO, 32'h8000);
    wr(`OFF_CTRL_ONE, 32'h8000);
    fire(72'h8);
    took(7'h0b, 24'h00011a, 4'h5);
    rd(`OFF_CSW, 32'he0);
    wr(`OFF_CSW, 32'h0);
    rd(`OFF_CSW, 32'he0);
    wr(`OFF_CTRL_ONE, 32'h0);
    wr(`OFF_CTRL_TWO, 32'h0);
    tidy();
    $display("alternate table test done");
  endtask : t_alt
  task automatic t_trap();
    @(posedge pclk);
    trap_evt <= 5'h01;
    @(posedge pclk);
    trap_evt <= 5'h00;
    took(7'h01, 24'h000006, 4'he);
    rd(`OFF_CTRL_ONE, 32'h2);
    rd(`OFF_CCW, 32'h8);
    rd(`OFF_CSW, 32'hc0);
    wr(`OFF_CCW, 32'h0);
    rd(`OFF_CCW, 32'h8);
    wr(`OFF_CTRL_ONE, 32'h0);
    wr(`OFF_CSW, 32'h0);
    fire(72'h8);
    quiet();
    wr(`OFF_FLAG_BASE, 32'h0);
    @(posedge pclk);
    trap_done <= 1'b1;
    @(posedge pclk);
    trap_done <= 1'b0;
    rd(`OFF_CCW, 32'h0);
    $display("trap test done");
  endtask : t_trap
  task automatic t_irq();
    wr(`OFF_EVT_CLR, 32'h3);
    wr(`OFF_EVT_ENA, 32'h1);
    fire(72'h8);
    took(7'h0b, 24'h00001a, 4'h5);
    check({31'h0, irq}, 32'h1);
    rd(`OFF_EVT_STS, 32'h1);
    wr(`OFF_EVT_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(`OFF_EVT_ENA, 32'h0);
    tidy();
    $display("event interrupt test done");
  endtask : t_irq
  // external pin 1 feeds request 20; negative edge polarity ignores the rising edge
  task automatic t_pin();
    wr(`OFF_CTRL_TWO, 32'h2);
    wr(`OFF_ENA_BASE + 12'h004, 32'h10);
    wr(`OFF_PRIO_BASE + 12'h014, 32'h3);
    @(posedge pclk);
    ext_pin <= 5'h02;
    quiet();
    @(posedge pclk);
    ext_pin <= 5'h00;
    took(7'h1c, 24'h00003c, 4'h3);
    rd(`OFF_FLAG_BASE + 12'h004, 32'h10);
    wr(`OFF_FLAG_BASE + 12'h004, 32'h0);
    wr(`OFF_CTRL_TWO, 32'h0);
    tidy();
    $display("external pin test done");
  endtask : t_pin
  // ==========================================================
  // main sequence; a hang ends in the same report
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_user();
    t_tie();
    t_masked();
    t_alt();
    t_trap();
    t_irq();
    t_pin();
    close_out();
  end
endmodule : vectored_interrupt_controller_test
